// >>> include/stmh_pkg.sv
// Constants and types of the target message handler.
// Assumes a single 20 MHz clock domain and an AHB-Lite register port.
package stmh_pkg;
  // ==========================================================
  // Bus widths and register offsets
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STAT   = 8'h04;
  localparam logic [7:0]  OFF_EVT    = 8'h08;
  localparam logic [7:0]  OFF_SENSE  = 8'h0c;
  localparam logic [7:0]  OFF_STBYTE = 8'h10;
  // ==========================================================
  // Field positions
  localparam int          CTRL_LUN_LO = 4;
  localparam int          EVT_W       = 7;
  localparam int          EV_SEL      = 0;
  localparam int          EV_CDB      = 1;
  localparam int          EV_ABORT    = 2;
  localparam int          EV_BDR      = 3;
  localparam int          EV_IDE      = 4;
  localparam int          EV_UNEXP    = 5;
  localparam int          EV_REJ      = 6;
  localparam int          ID_DISC_BIT = 6;
  localparam int          ST_CHK_BIT  = 1;
  // ==========================================================
  // Message codes
  localparam logic [7:0]  MSG_CMPL   = 8'h00;
  localparam logic [7:0]  MSG_SAVE   = 8'h02;
  localparam logic [7:0]  MSG_RESTORE= 8'h03;
  localparam logic [7:0]  MSG_DISC   = 8'h04;
  localparam logic [7:0]  MSG_IDE    = 8'h05;
  localparam logic [7:0]  MSG_ABORT  = 8'h06;
  localparam logic [7:0]  MSG_REJECT = 8'h07;
  localparam logic [7:0]  MSG_NOP    = 8'h08;
  localparam logic [7:0]  MSG_BDR    = 8'h0c;
  localparam logic [7:0]  MSG_IDENT  = 8'h80;
  localparam logic [7:0]  SENSE_IDE  = 8'h2d;
  // ==========================================================
  // Reset values and command block lengths
  localparam logic [7:0]  STBYTE_RST = 8'h00;
  localparam logic [3:0]  CDB_LEN_G0 = 4'h6;
  localparam logic [3:0]  CDB_LEN_G1 = 4'ha;
  localparam logic [2:0]  GRP_ONE    = 3'h1;
  // ==========================================================
  // Firmware commands written to the control register, bus phases and message kinds
  typedef enum logic [2:0] {
    FW_NONE, FW_COMPLETE, FW_DISCONNECT, FW_RESELECT,
    FW_RELEASE, FW_DATA_MOVED
  } stmh_fw_t;
  typedef enum logic [2:0] {
    PH_FREE, PH_CMD, PH_DATA, PH_STAT, PH_MIN, PH_MOUT
  } stmh_phase_t;
  typedef enum logic [1:0] {
    MK_IDENT, MK_BAD_ID, MK_OTHER
  } stmh_mkind_t;
endpackage : stmh_pkg

// >>> logic/stmh_ahb_slv.sv
// AHB-Lite slave front end: captures the address phase of each transfer.
// Assumes a single slave on the bus, zero wait states, OKAY answers only.
`timescale 1ns/1ps
module stmh_ahb_slv (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [stmh_pkg::ADDR_W-1:0] haddr,
  input  wire logic                      hready,
  output logic                           hreadyout_r,
  output logic                           hresp_r,
  output logic                           wr_r,
  output logic [stmh_pkg::ADDR_W-1:0]    wa_r
);
  import stmh_pkg::*;

  // ==========================================================
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wa_r <= '0;
    end else begin
      wr_r <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        wa_r <= haddr;
      end
    end
  end

  // Never stalls and never errors, so these stay constant flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end
endmodule : stmh_ahb_slv

// >>> logic/stmh_top.sv
// Message-phase handler of a disk target on the parallel peripheral bus.
// Assumes a bus sequencer that turns REQ/ACK handshakes into byte strobes.
`timescale 1ns/1ps
// Function
// [RULE_01] Initiator raises attention before selection to show message support.
// [RULE_02] Attention at selection makes the target request an identify byte.
// [RULE_03] Bus device reset is accepted as the first message-out byte.
// [RULE_04] After command complete the target drops busy and frees the bus.
// [RULE_05] Save data pointer code 02h tells initiator to save its state.
// [RULE_06] Initiator restores pointers to command start or last save.
// [RULE_07] Disconnect code 04h precedes busy release and saves no pointer.
// [RULE_08] Bus free without disconnect or complete flags a command error.
// [RULE_09] Initiator detected error posts error status with code 2D.
// [RULE_10] Abort clears only this initiator's operation, then frees bus.
// [RULE_11] Abort sends no status or ending message; idle unit is fine.
// [RULE_12] Initiator rejects with attention raised before releasing ACK.
// [RULE_13] Target sends its reject in message-in before asking more bytes.
// [RULE_14] Initiator with nothing to say answers no operation 08h.
// [RULE_15] Bus device reset clears all pending work, then frees the bus.
// [RULE_16] Identify has bit 7 set and a unit in bits 1 and 0.
// [RULE_17] Identify bit 6 says the initiator accepts disconnection.
// [RULE_18] Identify bits 5 to 2 are zero when sent.
// [RULE_19] Identify picks drive and disconnect right, then six or ten byte block.
// [RULE_20] Finishing a command sends status, command complete, then bus free.
// [RULE_21] Data already moved means save pointer right before disconnect.
// [RULE_22] Reselection sends identify, then restore pointers if data moved.
// [RULE_23] Initiator drops attention only at reset, bus free or last REQ.
// [RULE_24] Unsupported message-out codes are answered with message reject.
module stmh_top #(
  parameter int LUNS = 4
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [stmh_pkg::ADDR_W-1:0] haddr,
  input  wire logic [stmh_pkg::DATA_W-1:0] hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [stmh_pkg::DATA_W-1:0]      hrdata,
  input  wire logic                        bus_sel,
  input  wire logic                        bus_atn,
  input  wire logic                        bus_rst,
  input  wire logic                        rx_valid,
  input  wire logic [7:0]                  rx_byte,
  input  wire logic                        tx_ready,
  output logic                             tx_valid,
  output logic [7:0]                       tx_byte,
  output logic                             bsy,
  output stmh_pkg::stmh_phase_t            phase
);
  import stmh_pkg::*;

  typedef enum logic [2:0] {
    S_FREE, S_MOUT, S_CMD, S_BUSY, S_TX
  } stmh_state_t;

  // ==========================================================
  // Declarations
  stmh_state_t          st_r;
  stmh_phase_t          ph_r;
  logic                 bsy_r;
  logic                 txv_r;
  logic [7:0]           txb_r;
  logic [7:0]           qb_r [3];
  stmh_phase_t          qp_r [3];
  logic [1:0]           qn_r;
  logic                 endfree_r;
  logic [1:0]           lun_r;
  logic                 idv_r;
  logic                 disc_r;
  logic                 cdbok_r;
  logic [3:0]           cnt_r;
  logic [3:0]           len_r;
  logic [7:0]           opc_r;
  logic [LUNS-1:0]      pend_r;
  logic [LUNS-1:0]      moved_r;
  logic [EVT_W-1:0]     evt_r;
  logic [EVT_W-1:0]     set_nxt;
  logic [7:0]           stb_r;
  logic                 chk_r;
  logic [7:0]           sense_r;
  logic [DATA_W-1:0]    hrd_r;
  logic                 wr_r;
  logic [ADDR_W-1:0]    wa_r;
  logic                 fw_go;
  stmh_fw_t             fw_cmd;
  logic [1:0]           fw_lun;
  logic                 rd_ap;
  logic [DATA_W-1:0]    rd_mux;

  stmh_ahb_slv u_slv (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .haddr       (haddr),
    .hready      (hready),
    .hreadyout_r (hreadyout),
    .hresp_r     (hresp),
    .wr_r        (wr_r),
    .wa_r        (wa_r)
  );

  // ==========================================================
  // Message classification, shared by every message-out path
  function automatic stmh_mkind_t mkind(input logic [7:0] b);
    if (!b[7]) begin
      mkind = MK_OTHER;
    end else if (b[5:2] != 4'h0) begin
      mkind = MK_BAD_ID;                                   // see [RULE_18]
    end else begin
      mkind = MK_IDENT;                                    // see [RULE_16]
    end
  endfunction : mkind

  assign fw_go  = wr_r && (wa_r == OFF_CTRL);
  assign fw_cmd = stmh_fw_t'(hwdata[2:0]);
  assign fw_lun = hwdata[CTRL_LUN_LO +: 2];

  // ==========================================================
  // Phase sequencer, message queue and per-unit table
  // Reselect is only honoured on a free bus; the other commands only
  // while connected and idle, so firmware cannot corrupt a transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= S_FREE;
      ph_r      <= PH_FREE;
      bsy_r     <= 1'b0;
      txv_r     <= 1'b0;
      txb_r     <= 8'h00;
      qn_r      <= 2'd0;
      endfree_r <= 1'b0;
      lun_r     <= 2'd0;
      idv_r     <= 1'b0;
      disc_r    <= 1'b0;
      cdbok_r   <= 1'b0;
      cnt_r     <= 4'h0;
      len_r     <= CDB_LEN_G0;
      opc_r     <= 8'h00;
      pend_r    <= '0;
      moved_r   <= '0;
      for (int i = 0; i < 3; i++) begin
        qb_r[i] <= 8'h00;
        qp_r[i] <= PH_FREE;
      end
    end else if (bus_rst) begin
      // Reset condition: silent release, nothing counted as an error
      st_r    <= S_FREE;
      ph_r    <= PH_FREE;
      bsy_r   <= 1'b0;
      txv_r   <= 1'b0;
      qn_r    <= 2'd0;
      pend_r  <= '0;
      moved_r <= '0;
    end else begin
      unique case (st_r)
        S_FREE: begin
          if (bus_sel) begin
            bsy_r   <= 1'b1;
            idv_r   <= 1'b0;
            disc_r  <= 1'b0;
            cdbok_r <= 1'b0;
            cnt_r   <= 4'h0;
            if (bus_atn) begin
              st_r <= S_MOUT;                              // see [RULE_02]
              ph_r <= PH_MOUT;
            end else begin
              st_r <= S_CMD;
              ph_r <= PH_CMD;
            end
          end else if (fw_go && fw_cmd == FW_RESELECT) begin
            bsy_r    <= 1'b1;
            lun_r    <= fw_lun;
            idv_r    <= 1'b1;
            cdbok_r  <= 1'b1;
            qb_r[0]  <= MSG_IDENT | {6'h00, fw_lun};       // see [RULE_22]
            qp_r[0]  <= PH_MIN;
            qb_r[1]  <= MSG_RESTORE;
            qp_r[1]  <= PH_MIN;
            qn_r     <= moved_r[fw_lun] ? 2'd2 : 2'd1;     // see [RULE_22]
            endfree_r <= 1'b0;
            st_r     <= S_TX;
          end
        end
        S_MOUT: begin
          if (rx_valid) begin
            unique case (mkind(rx_byte))
              MK_IDENT: begin
                lun_r  <= rx_byte[1:0];                    // see [RULE_19]
                disc_r <= rx_byte[ID_DISC_BIT];            // see [RULE_19]
                idv_r  <= 1'b1;
              end
              MK_BAD_ID: begin
                qb_r[0] <= MSG_REJECT;                     // see [RULE_24]
                qp_r[0] <= PH_MIN;
                qn_r    <= 2'd1;
              end
              default: begin
                if (rx_byte == MSG_ABORT || rx_byte == MSG_BDR ||
                    rx_byte == MSG_IDE || rx_byte == MSG_NOP ||
                    rx_byte == MSG_REJECT) begin
                  qn_r <= 2'd0;
                end else begin
                  qb_r[0] <= MSG_REJECT;                   // see [RULE_24]
                  qp_r[0] <= PH_MIN;
                  qn_r    <= 2'd1;
                end
              end
            endcase
            if (rx_byte == MSG_BDR) begin
              pend_r  <= '0;                               // see [RULE_15]
              moved_r <= '0;                               // see [RULE_03]
              bsy_r   <= 1'b0;
              st_r    <= S_FREE;
              ph_r    <= PH_FREE;
            end else if (rx_byte == MSG_ABORT) begin
              // Before identify or a full command block nothing is on the bus
              pend_r[lun_r]  <= pend_r[lun_r] && !(idv_r || cdbok_r); // see [RULE_10]
              moved_r[lun_r] <= moved_r[lun_r] && !(idv_r || cdbok_r);
              bsy_r <= 1'b0;                               // see [RULE_11]
              st_r  <= S_FREE;
              ph_r  <= PH_FREE;
            end else if (mkind(rx_byte) == MK_BAD_ID || (!rx_byte[7] &&
                     rx_byte != MSG_IDE && rx_byte != MSG_NOP &&
                     rx_byte != MSG_REJECT)) begin
              endfree_r <= 1'b0;
              st_r      <= S_TX;                           // see [RULE_13]
            end else if (!bus_atn) begin
              st_r <= cdbok_r ? S_BUSY : S_CMD;
              ph_r <= cdbok_r ? PH_DATA : PH_CMD;
            end
          end
        end
        S_CMD: begin
          if (bus_atn && cnt_r == 4'h0) begin
            st_r <= S_MOUT;
            ph_r <= PH_MOUT;
          end else if (rx_valid) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h0) begin
              opc_r <= rx_byte;
              len_r <= (rx_byte[7:5] == GRP_ONE) ? CDB_LEN_G1 : CDB_LEN_G0; // see [RULE_19]
            end
            if (cnt_r == 4'h1 && !idv_r) begin
              lun_r <= rx_byte[6:5];
            end
            if (cnt_r == len_r - 4'h1) begin
              cdbok_r       <= 1'b1;
              pend_r[lun_r] <= 1'b1;
              st_r          <= S_BUSY;
              ph_r          <= PH_DATA;
            end
          end
        end
        S_BUSY: begin
          if (bus_atn) begin
            st_r <= S_MOUT;
            ph_r <= PH_MOUT;
          end else if (fw_go) begin
            unique case (fw_cmd)
              FW_COMPLETE: begin
                qb_r[0] <= chk_r ? (stb_r | 8'h02) : stb_r; // see [RULE_20]
                qp_r[0] <= PH_STAT;
                qb_r[1] <= MSG_CMPL;                       // see [RULE_04]
                qp_r[1] <= PH_MIN;
                qn_r    <= 2'd2;
                endfree_r <= 1'b1;
                pend_r[lun_r]  <= 1'b0;
                moved_r[lun_r] <= 1'b0;
                st_r <= S_TX;
              end
              FW_DISCONNECT: begin
                if (disc_r) begin
                  if (moved_r[lun_r]) begin
                    qb_r[0] <= MSG_SAVE;                   // see [RULE_21]
                    qb_r[1] <= MSG_DISC;                   // see [RULE_07]
                    qn_r    <= 2'd2;
                  end else begin
                    qb_r[0] <= MSG_DISC;                   // see [RULE_07]
                    qn_r    <= 2'd1;
                  end
                  qp_r[0]   <= PH_MIN;
                  qp_r[1]   <= PH_MIN;
                  endfree_r <= 1'b1;
                  st_r      <= S_TX;
                end
              end
              FW_RELEASE: begin
                bsy_r <= 1'b0;                             // see [RULE_08]
                st_r  <= S_FREE;
                ph_r  <= PH_FREE;
              end
              FW_DATA_MOVED: begin
                moved_r[lun_r] <= 1'b1;                    // see [RULE_05]
              end
              default: begin
              end
            endcase
          end
        end
        S_TX: begin
          if (!txv_r) begin
            txv_r <= 1'b1;
            txb_r <= qb_r[0];
            ph_r  <= qp_r[0];
          end else if (tx_ready) begin
            txv_r <= 1'b0;
            qb_r[0] <= qb_r[1];
            qp_r[0] <= qp_r[1];
            qb_r[1] <= qb_r[2];
            qp_r[1] <= qp_r[2];
            qn_r    <= qn_r - 2'd1;
            if (qn_r == 2'd1) begin
              if (endfree_r) begin
                bsy_r <= 1'b0;                             // see [RULE_04]
                st_r  <= S_FREE;
                ph_r  <= PH_FREE;
              end else if (bus_atn) begin
                st_r <= S_MOUT;                            // see [RULE_12]
                ph_r <= PH_MOUT;
              end else begin
                st_r <= cdbok_r ? S_BUSY : S_CMD;
                ph_r <= cdbok_r ? PH_DATA : PH_CMD;
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Sticky event flags; a new event wins over a same-cycle clear
  always_comb begin
    set_nxt = '0;
    set_nxt[EV_SEL]   = (st_r == S_FREE) && bus_sel && !bus_rst;
    set_nxt[EV_CDB]   = (st_r == S_CMD) && rx_valid && !bus_rst &&
                        !(bus_atn && cnt_r == 4'h0) && (cnt_r == len_r - 4'h1);
    set_nxt[EV_ABORT] = (st_r == S_MOUT) && rx_valid && !bus_rst &&
                        (rx_byte == MSG_ABORT);
    set_nxt[EV_BDR]   = (st_r == S_MOUT) && rx_valid && !bus_rst &&
                        (rx_byte == MSG_BDR);
    set_nxt[EV_IDE]   = (st_r == S_MOUT) && rx_valid && !bus_rst &&
                        (rx_byte == MSG_IDE);
    set_nxt[EV_UNEXP] = (st_r == S_BUSY) && fw_go && !bus_atn && !bus_rst &&
                        (fw_cmd == FW_RELEASE);            // see [RULE_08]
    set_nxt[EV_REJ]   = (st_r == S_MOUT) && rx_valid && !bus_rst &&
                        (rx_byte == MSG_REJECT);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_r <= '0;
    end else if (wr_r && wa_r == OFF_EVT) begin
      evt_r <= (evt_r & ~hwdata[EVT_W-1:0]) | set_nxt;
    end else begin
      evt_r <= evt_r | set_nxt;
    end
  end

  // ==========================================================
  // Error status: initiator error forces check condition and sense 2D
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_r   <= 1'b0;
      sense_r <= 8'h00;
    end else if (set_nxt[EV_IDE]) begin
      chk_r   <= 1'b1;                                     // see [RULE_09]
      sense_r <= SENSE_IDE;                                // see [RULE_09]
    end else if (set_nxt[EV_SEL] || (st_r == S_FREE && fw_go &&
                 fw_cmd == FW_RESELECT)) begin
      chk_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stb_r <= STBYTE_RST;
    end else if (wr_r && wa_r == OFF_STBYTE) begin
      stb_r <= hwdata[7:0];
    end
  end

  // ==========================================================
  // Register read, registered in the address phase
  assign rd_ap = hsel && htrans[1] && hready && !hwrite;

  always_comb begin
    unique case (haddr)
      OFF_STAT:   rd_mux = {16'h0000, opc_r, cdbok_r, idv_r, disc_r,
                            lun_r, 3'(st_r)};
      OFF_EVT:    rd_mux = {{(DATA_W-EVT_W){1'b0}}, evt_r};
      OFF_SENSE:  rd_mux = {23'h000000, chk_r, sense_r};
      OFF_STBYTE: rd_mux = {24'h000000, stb_r};
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrd_r <= '0;
    end else if (rd_ap) begin
      hrd_r <= rd_mux;
    end
  end

  assign hrdata   = hrd_r;
  assign tx_valid = txv_r;
  assign tx_byte  = txb_r;
  assign bsy      = bsy_r;
  assign phase    = ph_r;
endmodule : stmh_top

// >>> test/stmh_init_model.sv
// Initiator model: takes message-in bytes from the target.
// Assumes tx_valid and tx_byte hold until tx_ready.
`timescale 1ns/1ps
module stmh_init_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  // ====
  // Byte log and handshake
  logic [7:0] got_q[$];
  logic [2:0] wait_r;
  // Slow mode lets the target hold a byte for several cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ready <= 1'b0;
      wait_r   <= 3'h0;
    end else if (tx_valid && !tx_ready && (!slow || wait_r == 3'h5)) begin
      tx_ready <= 1'b1;
      wait_r   <= 3'h0;
      got_q.push_back(tx_byte);
    end else begin
      tx_ready <= 1'b0;
      wait_r   <= tx_valid ? wait_r + 3'h1 : 3'h0;
    end
  end
endmodule : stmh_init_model

// >>> test/stmh_top_asserts.sv
// Checker of the handler's link outputs against its link inputs.
// Assumes binding onto stmh_top; one clock, active-low reset.
`timescale 1ns/1ps
module stmh_top_asserts (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  bus_sel,
  input wire logic                  bus_atn,
  input wire logic                  rx_valid,
  input wire logic [7:0]            rx_byte,
  input wire logic                  tx_ready,
  input wire logic                  tx_valid,
  input wire logic [7:0]            tx_byte,
  input wire logic                  bsy,
  input wire stmh_pkg::stmh_phase_t phase
);
  import stmh_pkg::*;
  // ====
  // Assertions
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic mout_rx;
  logic min_done;
  assign mout_rx  = rx_valid && phase == PH_MOUT;
  assign min_done = tx_valid && tx_ready && phase == PH_MIN;
  sel_mout_a: assert property (
    bus_sel && bus_atn && phase == PH_FREE |-> ##[1:3] phase == PH_MOUT) else $error("no message-out");
  cmpl_free_a: assert property (
    min_done && tx_byte == MSG_CMPL |-> ##[1:2] !bsy && phase == PH_FREE) else $error("busy after complete");
  disc_free_a: assert property (
    min_done && tx_byte == MSG_DISC |-> ##[1:2] !bsy) else $error("busy after disconnect");
  abort_free_a: assert property (
    mout_rx && rx_byte == MSG_ABORT |-> ##[1:2] phase == PH_FREE) else $error("bus kept after abort");
  abort_quiet_a: assert property (
    mout_rx && rx_byte == MSG_ABORT |=> !tx_valid [*3]) else $error("byte sent after abort");
  reset_free_a: assert property (
    mout_rx && rx_byte == MSG_BDR |-> ##[1:2] !bsy && phase == PH_FREE) else $error("busy after device reset");
  reject_out_a: assert property (
    mout_rx && rx_byte == 8'h01 |-> ##[1:6] tx_valid && tx_byte == MSG_REJECT && phase == PH_MIN)
    else $error("no reject sent");
  ident_zero_a: assert property (
    tx_valid && phase == PH_MIN && tx_byte[7] |-> tx_byte[5:2] == 4'h0) else $error("identify reserved bits");
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("byte dropped early");
endmodule : stmh_top_asserts
bind stmh_top stmh_top_asserts u_chk (.hclk, .hresetn, .bus_sel, .bus_atn, .rx_valid, .rx_byte, .tx_ready,
  .tx_valid, .tx_byte, .bsy, .phase);

// >>> test/tb_top.sv
// Bench for the message handler: AHB-Lite firmware side and link side.
// Assumes stmh_init_model answers the message-in bytes.
`timescale 1ns/1ps
module tb_top;
  import stmh_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic        bus_sel, bus_atn, rx_valid, tx_ready, tx_valid, bsy;
  logic [1:0]  htrans;
  logic [7:0]  haddr, rx_byte, tx_byte, lun, st;
  logic [31:0] hwdata, hrdata, q;
  stmh_phase_t phase;
  int          fails, n_compared;
  stmh_top DUT (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hsize(3'h2), .haddr, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .bus_sel, .bus_atn, .bus_rst(1'b0), .rx_valid, .rx_byte, .tx_ready,
    .tx_valid, .tx_byte, .bsy, .phase);
  stmh_init_model u_ini (.hclk, .hresetn, .slow, .tx_valid, .tx_byte, .tx_ready);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ====
  // Tasks
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hang();
    fails++;
    stop_test();
  endtask : hang
  task automatic rdy_edge();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      if (++n > 20) hang();
    end while (hreadyout !== 1'b1);
  endtask : rdy_edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    rdy_edge();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    rdy_edge();
    q = hrdata;
  endtask : ahb
  // Sampled at the falling edge so that the rising edge's updates have landed
  task automatic wait_for(input stmh_phase_t p, input int k);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      if (++n > 80) hang();
    end while (phase !== p || u_ini.got_q.size() < k);
    @(posedge hclk);
  endtask : wait_for
  task automatic send(input logic [7:0] b, input logic a);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    bus_atn  <= a;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
    repeat (2) @(posedge hclk);
  endtask : send
  task automatic select(input logic a);
    bus_atn <= a;
    @(posedge hclk);
    bus_sel <= 1'b1;
    @(posedge hclk);
    bus_sel <= 1'b0;
  endtask : select
  task automatic cdb(input logic [7:0] op, input int len);
    send(op, 1'b0);
    repeat (len - 1) send(8'($urandom) & 8'h9f, 1'b0);
  endtask : cdb
  task automatic got(input logic [7:0] e);
    chk("msg_in", u_ini.got_q.size() ? u_ini.got_q.pop_front() : 8'hxx, e);
  endtask : got
  function automatic logic [7:0] ident(input logic [7:0] l, input logic d);
    return MSG_IDENT | {1'b0, d, 4'h0, l[1:0]};
  endfunction : ident
  // ====
  // Scenarios
  initial begin
    {hresetn, hsel, hwrite, slow, bus_sel, bus_atn, rx_valid, htrans} = '0;
    {haddr, hwdata, rx_byte, fails, n_compared} = '0;
    void'($urandom(32'hf54fe510));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("phase", {hresp, bsy, phase}, {2'b00, PH_FREE});
    ahb(0, OFF_STBYTE, 0);
    chk("stbyte", q, STBYTE_RST);
    ahb(0, 8'h20, 0);
    chk("unmapped", q, 0);
    lun = 8'($urandom_range(3, 0));
    select(1);
    wait_for(PH_MOUT, 0);
    send(ident(lun, 1), 0);
    wait_for(PH_CMD, 0);
    cdb(8'h08, CDB_LEN_G0);
    ahb(0, OFF_STAT, 0);
    chk("stat", q[15:3], {8'h08, 3'b111, lun[1:0]});
    ahb(1, OFF_CTRL, 5);
    ahb(1, OFF_CTRL, 2);
    wait_for(PH_FREE, 2);
    got(MSG_SAVE);
    got(MSG_DISC);
    ahb(0, OFF_EVT, 0);
    chk("evt", q[6:0], 7'h03);
    ahb(1, OFF_EVT, 32'h7f);
    slow <= 1'b1;
    ahb(1, OFF_CTRL, {lun[1:0], 4'h3});
    wait_for(PH_DATA, 2);
    got(ident(lun, 0));
    got(MSG_RESTORE);
    st = 8'($urandom) & 8'hfd;
    ahb(1, OFF_STBYTE, st);
    ahb(1, OFF_CTRL, 1);
    wait_for(PH_FREE, 2);
    got(st);
    got(MSG_CMPL);
    slow <= 1'b0;
    select(1);
    wait_for(PH_MOUT, 0);
    send(8'h84, 1);
    wait_for(PH_MOUT, 1);
    got(MSG_REJECT);
    send(8'h01, 1);
    wait_for(PH_MOUT, 1);
    got(MSG_REJECT);
    send(MSG_ABORT, 0);
    wait_for(PH_FREE, 0);
    ahb(0, OFF_EVT, 0);
    chk("abort", {u_ini.got_q.size() == 0, q[EV_ABORT]}, 2'b11);
    ahb(1, OFF_EVT, 32'h7f);
    select(1);
    wait_for(PH_MOUT, 0);
    send(ident(lun, 0), 1);
    send(MSG_NOP, 1);
    send(MSG_IDE, 0);
    wait_for(PH_CMD, 0);
    ahb(0, OFF_SENSE, 0);
    chk("sense", q[8:0], {1'b1, SENSE_IDE});
    cdb(8'h28, CDB_LEN_G1);
    ahb(1, OFF_STBYTE, 0);
    ahb(1, OFF_CTRL, 1);
    wait_for(PH_FREE, 2);
    got(8'h02);
    got(MSG_CMPL);
    select(1);
    wait_for(PH_MOUT, 0);
    send(MSG_BDR, 0);
    wait_for(PH_FREE, 0);
    ahb(0, OFF_EVT, 0);
    chk("evt_bdr", q[EV_BDR], 1);
    select(0);
    wait_for(PH_CMD, 0);
    cdb(8'h08, CDB_LEN_G0);
    ahb(1, OFF_CTRL, 4);
    wait_for(PH_FREE, 0);
    ahb(0, OFF_EVT, 0);
    chk("evt_unexp", q[EV_UNEXP], 1);
    stop_test();
  end
endmodule : tb_top
